// >>> logic/flash_host.sv
// Purpose: Host controller for a flash die
// Assumes: 40 MHz mclk; board pull-up
// Notes:   Completion from busy pin and toggle bit
// What this block does
// - Open-drain busy pin, host supplies pull-up
// - Aborted operation needs full reissue
// - Host clears command state before commands other than read/suspend/resume
// - Poll address is the request address for every mode; protect query uses query_addr
// - Write strobe high during flash reads; static RAM never selected
`timescale 1ns/1ps
`include "flash_host_map.svh"

module flash_host (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // User side
    input  wire logic                 req,
    input  wire flash_host_pkg::op_t  op,
    input  wire logic [20:0]          req_addr,
    input  wire logic [15:0]          req_data,
    input  wire logic                 supply_ok,
    output logic                      ack,
    output logic                      busy,
    output logic [15:0]               rsp_data_reg,
    output logic                      rsp_fail_reg,
    output logic                      suspended_reg,
    // Flash pins
    output logic [20:0]               flash_addr,
    output logic [15:0]               dq_out,
    output logic                      dq_oe,
    input  wire logic [15:0]          dq_in,
    output logic                      we_n,
    output logic                      oe_n,
    output logic                      flash_select_n,
    output logic                      sram_select_low_n,
    output logic                      sram_select_high,
    output logic                      ready_busy_pullup_en,
    input  wire logic                 ready_busy_out
);
    typedef enum logic [2:0] {
        h_idle, h_clear, h_seq, h_wait, h_poll, h_done
    } host_t;

    host_t               st_reg;        // Main sequencer state
    flash_host_pkg::op_t op_reg;        // Operation in flight
    logic [20:0]         addr_reg;      // Target / poll address
    logic [15:0]         data_reg;      // Program data
    logic [2:0]          step_reg;      // Index of command cycle
    logic [2:0]          nsteps;        // Command cycles for op_reg
    logic                rb_meta_reg;   // First sync stage of busy pin
    logic                rb_sync_reg;   // Second sync stage
    logic                sup_meta_reg;  // First sync stage of supply flag
    logic                sup_sync_reg;  // Second sync stage
    logic                toggle_seen_reg; // Previous toggle bit sample
    logic                have_prev_reg; // A toggle sample exists
    logic                go;            // Start one bus cycle
    logic                wr;            // Bus cycle is a write
    logic [20:0]         cyc_addr;      // Bus cycle address
    logic [15:0]         cyc_data;      // Bus cycle write data
    logic                cyc_done;      // Bus cycle finished
    logic [15:0]         cyc_rdata;     // Bus cycle read data
    logic                bus_active_reg; // A bus cycle is in flight

    // Static RAM never selected: floats, no write strobe
    assign sram_select_low_n = 1'b1;
    assign sram_select_high  = 1'b0;

    // Open-drain busy pin: pull-up always on
    assign ready_busy_pullup_en = 1'b1;

    // Two-flop sync of busy pin and supply
    always_ff @(posedge mclk) begin
        rb_meta_reg  <= ready_busy_out;
        rb_sync_reg  <= rb_meta_reg;
        sup_meta_reg <= supply_ok;
        sup_sync_reg <= sup_meta_reg;
    end

    // Command cycles per operation
    always_comb begin
        case (op_reg)
            flash_host_pkg::op_program:       nsteps = 3'h4;
            flash_host_pkg::op_chip_erase:    nsteps = 3'h6;
            flash_host_pkg::op_block_erase:   nsteps = 3'h6;
            flash_host_pkg::op_protect_query: nsteps = 3'h3;
            default:                          nsteps = 3'h1;
        endcase
    end

    // Address and data of the current command cycle
    always_comb begin
        cyc_addr = `UNLOCK_ADDR1;
        cyc_data = `UNLOCK_DATA1;
        if (st_reg == h_clear) begin
            cyc_data = `CMD_RESET;
        end else if (st_reg == h_poll ||
                     op_reg == flash_host_pkg::op_read) begin
            cyc_addr = addr_reg;
        end else if (op_reg == flash_host_pkg::op_suspend) begin
            cyc_addr = addr_reg;
            cyc_data = `CMD_SUSPEND;
        end else if (op_reg == flash_host_pkg::op_resume) begin
            cyc_addr = addr_reg;
            cyc_data = `CMD_RESUME;
        end else if (op_reg == flash_host_pkg::op_reset) begin
            cyc_data = `CMD_RESET;
        end else if (step_reg == 3'h1 || step_reg == 3'h4) begin
            cyc_addr = `UNLOCK_ADDR2;
            cyc_data = `UNLOCK_DATA2;
        end else if (step_reg == 3'h2) begin
            if (op_reg == flash_host_pkg::op_program) begin
                cyc_data = `CMD_PROGRAM;
            end else if (op_reg == flash_host_pkg::op_protect_query) begin
                cyc_data = `CMD_ID_READ;
            end else begin
                cyc_data = `CMD_ERASE;
            end
        end else if (step_reg == 3'h3 &&
                     op_reg == flash_host_pkg::op_program) begin
            cyc_addr = addr_reg;
            cyc_data = data_reg;
        end else if (step_reg == 3'h5) begin
            if (op_reg == flash_host_pkg::op_block_erase) begin
                cyc_addr = addr_reg;
                cyc_data = `CMD_BLOCK_ERASE;
            end else begin
                cyc_data = `CMD_CHIP_ERASE;
            end
        end
    end

    // Query reads block address, low bits 0,1,0
    logic [20:0] query_addr;
    assign query_addr = {addr_reg[20:3], `PROT_QUERY_LOW};

    assign go = (st_reg == h_clear || st_reg == h_seq || st_reg == h_poll)
                && !cyc_done && !bus_active_reg;
    assign wr = (st_reg != h_poll) && !(op_reg == flash_host_pkg::op_read);

    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_active_reg <= 1'b0;
        end else if (go) begin
            bus_active_reg <= 1'b1;
        end else if (cyc_done) begin
            bus_active_reg <= 1'b0;
        end
    end

    bus_cycle u_cycle (
        .mclk               (mclk),
        .rst                (rst),
        .go                 (go),
        .wr                 (wr),
        .addr               ((st_reg == h_poll &&
                              op_reg == flash_host_pkg::op_protect_query)
                             ? query_addr : cyc_addr),
        .wdata              (cyc_data),
        .done               (cyc_done),
        .rdata_reg          (cyc_rdata),
        .addr_reg           (flash_addr),
        .dq_out_reg         (dq_out),
        .dq_oe_reg          (dq_oe),
        .we_n_reg           (we_n),
        .oe_n_reg           (oe_n),
        .flash_select_n_reg (flash_select_n),
        .dq_in              (dq_in)
    );

    // Main sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg          <= h_idle;
            op_reg          <= flash_host_pkg::op_read;
            addr_reg        <= 21'h000000;
            data_reg        <= 16'h0000;
            step_reg        <= 3'h0;
            rsp_data_reg    <= 16'h0000;
            rsp_fail_reg    <= 1'b0;
            suspended_reg   <= 1'b0;
            toggle_seen_reg <= 1'b0;
            have_prev_reg   <= 1'b0;
        end else begin
            case (st_reg)
                h_idle: begin
                    // Held back below lockout
                    if (req && sup_sync_reg) begin
                        op_reg   <= op;
                        addr_reg <= req_addr;
                        data_reg <= req_data;
                        step_reg <= 3'h0;
                        rsp_fail_reg <= 1'b0;
                        // No reset before suspend/resume
                        if (op == flash_host_pkg::op_suspend ||
                            op == flash_host_pkg::op_resume ||
                            op == flash_host_pkg::op_read) begin
                            st_reg <= h_seq;
                        end else begin
                            st_reg <= h_clear;
                        end
                    end
                end
                h_clear: begin
                    if (cyc_done) begin
                        st_reg <= h_seq;
                    end
                end
                h_seq: begin
                    if (cyc_done) begin
                        if (op_reg == flash_host_pkg::op_read) begin
                            rsp_data_reg <= cyc_rdata;
                            st_reg       <= h_done;
                        end else if (step_reg == nsteps - 3'h1) begin
                            have_prev_reg <= 1'b0;
                            st_reg <= (op_reg ==
                                       flash_host_pkg::op_protect_query)
                                      ? h_poll : h_wait;
                        end else begin
                            step_reg <= step_reg + 3'h1;
                        end
                    end
                end
                h_wait: begin
                    suspended_reg <= (op_reg ==
                                      flash_host_pkg::op_suspend);
                    st_reg <= h_poll;
                end
                h_poll: begin
                    if (!sup_sync_reg) begin
                        rsp_fail_reg <= 1'b1;  // Aborted, reissue
                        st_reg       <= h_done;
                    end else if (cyc_done) begin
                        rsp_data_reg    <= cyc_rdata;
                        toggle_seen_reg <= cyc_rdata[`TOGGLE_BIT];
                        have_prev_reg   <= 1'b1;
                        if (op_reg == flash_host_pkg::op_protect_query) begin
                            // 01h means protected
                            rsp_fail_reg <= (cyc_rdata[7:0] == `PROT_YES);
                            st_reg       <= h_done;
                        end else if (have_prev_reg && rb_sync_reg &&
                            cyc_rdata[`TOGGLE_BIT] == toggle_seen_reg) begin
                            // Ready and toggling stopped
                            st_reg <= h_done;
                        end else if (!rb_sync_reg && cyc_rdata[`TIMEOUT_BIT] &&
                            cyc_rdata[`TOGGLE_BIT] != toggle_seen_reg) begin
                            // Failure keeps busy low; reset clears
                            rsp_fail_reg <= 1'b1;
                            op_reg       <= flash_host_pkg::op_reset;
                            step_reg     <= 3'h0;
                            st_reg       <= h_seq;
                        end
                        // Else busy low, still toggling or no earlier sample
                    end
                end
                default: begin
                    st_reg <= h_idle;
                end
            endcase
        end
    end

    // Done pulse; busy while not idle
    assign ack  = (st_reg == h_done);
    assign busy = (st_reg != h_idle);

endmodule : flash_host

// >>> logic/flash_host_map.svh
// Purpose: Host controller constants
// Assumes: 40 MHz mclk, 16-bit word mode
// Notes:   Codes and counts as macros
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// Strobe phase in ns and cycles, rounded up
`define STROBE_NS        50
`define CLK_NS           25
`define STROBE_CYC       ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
// Unlock cycles, word mode
`define UNLOCK_ADDR1     21'h000555
`define UNLOCK_ADDR2     21'h0002AA
`define UNLOCK_DATA1     16'h00AA
`define UNLOCK_DATA2     16'h0055
`define CMD_RESET        16'h00F0
`define CMD_PROGRAM      16'h00A0
`define CMD_ERASE        16'h0080
`define CMD_CHIP_ERASE   16'h0010
`define CMD_BLOCK_ERASE  16'h0030
`define CMD_SUSPEND      16'h00B0
`define CMD_RESUME       16'h0030
`define CMD_ID_READ      16'h0090
// Protection query bits and answer
`define PROT_QUERY_LOW   3'h2
`define PROT_YES         8'h01
// Status bit positions
`define POLL_BIT         7
`define TOGGLE_BIT       6
`define TIMEOUT_BIT      5

`endif

// >>> logic/flash_host_pkg.sv
// Purpose: Host controller types
// Assumes: Constants in the map header
// Notes:   Holds only types
package flash_host_pkg;

    // User operation codes
    typedef enum logic [2:0] {
        op_read,
        op_program,
        op_chip_erase,
        op_block_erase,
        op_suspend,
        op_resume,
        op_reset,
        op_protect_query
    } op_t;

endpackage : flash_host_pkg

// >>> logic/bus_cycle.sv
// Purpose: One flash bus cycle, read or write
// Assumes: Data bus pins already split
// Notes:   Reads sample a synchronised copy
`timescale 1ns/1ps
`include "flash_host_map.svh"

module bus_cycle (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [20:0] addr,
    input  wire logic [15:0] wdata,
    output logic             done,
    output logic [15:0]      rdata_reg,
    output logic [20:0]      addr_reg,
    output logic [15:0]      dq_out_reg,
    output logic             dq_oe_reg,
    output logic             we_n_reg,
    output logic             oe_n_reg,
    output logic             flash_select_n_reg,
    input  wire logic [15:0] dq_in
);
    typedef enum logic [1:0] {s_idle, s_strobe, s_hold} cyc_t;

    cyc_t        st_reg;       // Cycle phase
    logic [3:0]  cnt_reg;      // Phase counter
    logic [15:0] dq_meta_reg;  // First sync stage, read only by second
    logic [15:0] dq_sync_reg;  // Second sync stage

    // Pins are asynchronous: two flops first
    always_ff @(posedge mclk) begin
        dq_meta_reg <= dq_in;
        dq_sync_reg <= dq_meta_reg;
    end

    // Strobe sequencing; reads sample at strobe end
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg             <= s_idle;
            cnt_reg            <= 4'h0;
            addr_reg           <= 21'h000000;
            dq_out_reg         <= 16'h0000;
            dq_oe_reg          <= 1'b0;
            we_n_reg           <= 1'b1;
            oe_n_reg           <= 1'b1;
            flash_select_n_reg <= 1'b1;
            rdata_reg          <= 16'h0000;
        end else begin
            case (st_reg)
                s_idle: begin
                    if (go) begin
                        st_reg             <= s_strobe;
                        cnt_reg            <= 4'(`STROBE_CYC + 2);
                        addr_reg           <= addr;
                        dq_out_reg         <= wdata;
                        dq_oe_reg          <= wr;
                        we_n_reg           <= ~wr;
                        oe_n_reg           <= wr;
                        flash_select_n_reg <= 1'b0;
                    end
                end
                s_strobe: begin
                    // Two extra clocks cover read sync delay
                    if (cnt_reg == 4'h1) begin
                        st_reg             <= s_hold;
                        cnt_reg            <= 4'(`STROBE_CYC);
                        rdata_reg          <= dq_sync_reg;
                        we_n_reg           <= 1'b1;  // Rising edge latches
                        oe_n_reg           <= 1'b1;
                        flash_select_n_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: begin
                    // Hold data past the edge, then release
                    if (cnt_reg == 4'h1) begin
                        st_reg    <= s_idle;
                        dq_oe_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
            endcase
        end
    end

    // Done at hold end
    assign done = (st_reg == s_hold) && (cnt_reg == 4'h1);

endmodule : bus_cycle

// >>> dv/flash_host_props.sv
// Purpose: Host controller port checks
// Assumes: One mclk domain
// Notes:   Bound from the bench top
`timescale 1ns/1ps

module flash_host_props (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        supply_ok,
    input wire logic        ack,
    input wire logic        busy,
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic        flash_select_n,
    input wire logic        sram_select_low_n,
    input wire logic        sram_select_high,
    input wire logic        ready_busy_pullup_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Reset idles strobes and bus
    reset_idle_a: assert property (disable iff (1'b0)
        rst |=> we_n && oe_n && flash_select_n && !dq_oe)
        else $error("strobes not idle after reset");
    // No drive while the die drives
    read_float_a: assert property (
        !oe_n |-> !dq_oe) else $error("bus driven during read");
    // Static RAM stays deselected
    sram_off_a: assert property (
        sram_select_low_n && !sram_select_high)
        else $error("static RAM selected");
    // Pull-up stays enabled
    pullup_on_a: assert property (
        ready_busy_pullup_en) else $error("pull-up disabled");
    // Data held to latching edge
    write_hold_a: assert property (
        $rose(we_n) |-> dq_oe && $stable(dq_out) && $stable(flash_addr))
        else $error("write data moved");
    // Full-width write strobe
    write_width_a: assert property (
        $fell(we_n) |-> !we_n [*2]) else $error("write strobe too short");
    // Reads select die, no write strobe
    read_sel_a: assert property (
        $fell(oe_n) |-> !flash_select_n && we_n)
        else $error("read without select");
    // Low supply keeps idle
    lockout_a: assert property (
        (!busy && !supply_ok) [*3] |=> !busy)
        else $error("taken under lockout");
    // One-cycle completion pulse
    ack_end_a: assert property (
        ack |=> !ack && !busy) else $error("ack too long");
endmodule : flash_host_props

// >>> dv/flash_dev_model.sv
// Purpose: Behavioural flash die
// Assumes: Word mode; latch at write end
// Notes:   Busy time counts status reads
`timescale 1ns/1ps
`include "flash_host_map.svh"

module flash_dev_model (
    input  wire logic [20:0] flash_addr,
    input  wire logic [15:0] dq_out,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        flash_select_n,
    input  wire logic        supply_ok,
    output logic      [15:0] dq_in,
    output logic             rb_low
);
    logic [15:0] mem [logic [20:0]]; // Absent word reads as erased
    logic [15:0] pd, rd_val = 16'h0000; // Program data, last word out
    logic [20:0] pa;                    // Operation address
    logic [2:0]  seq = 3'h0;            // Step in the command sequence
    logic busy = 1'b0, ers = 1'b0, chip = 1'b0, idm = 1'b0;
    logic jam = 1'b0, tgl = 1'b0, fail_now = 1'b0, fail_next = 1'b0;
    logic skip = 1'b0;                  // Power-up latch skip
    logic [5:0]  prot_blk = 6'h3F;      // Protected block, set by bench
    int          busy_reads = 4;        // Status reads until done
    int          left, bad_polls = 0;
    wire wr = !we_n && !flash_select_n;
    wire rd = !oe_n && !flash_select_n;

    // Pull-down only
    assign rb_low = busy;
    // Released bus shows the inverse
    assign dq_in = rd ? rd_val : ~rd_val;
    // Powered up with all strobes low: drop the first latch
    initial #0 skip = (we_n === 1'b0 && flash_select_n === 1'b0 &&
                       oe_n === 1'b0);

    task automatic start(input logic e);
        busy = 1'b1;
        ers = e;
        seq = 3'h0;
        left = busy_reads;
        fail_now = fail_next;
        fail_next = 1'b0;
    endtask : start

    task automatic step(input logic [20:0] a, input logic [15:0] d);
        logic u1, u2;
        u1 = a == `UNLOCK_ADDR1;
        u2 = a == `UNLOCK_ADDR2;
        if (seq == 3'h6) begin
            pa = a;
            pd = d;
            start(1'b0);
        end else if (seq == 3'h5 && (d == `CMD_CHIP_ERASE ||
                     d == `CMD_BLOCK_ERASE)) begin
            pa = a;
            chip = d == `CMD_CHIP_ERASE;
            start(1'b1);
        end else if ((seq == 3'h0 || seq == 3'h3) && u1 &&
                     d == `UNLOCK_DATA1) seq++;
        else if ((seq == 3'h1 || seq == 3'h4) && u2 &&
                 d == `UNLOCK_DATA2) seq++;
        else if (seq == 3'h2 && u1 && d == `CMD_PROGRAM) seq = 3'h6;
        else if (seq == 3'h2 && u1 && d == `CMD_ERASE) seq = 3'h3;
        else if (seq == 3'h2 && u1 && d == `CMD_ID_READ) idm = 1'b1;
        else jam = 1'b1; // Stray word sticks until reset
    endtask : step

    // Latch at closing strobe edge
    always @(negedge wr) begin
        if (skip || !supply_ok || $isunknown(dq_out))
            skip = 1'b0;
        else if (dq_out == `CMD_RESET && !(busy && !fail_now)) begin
            seq = 3'h0; // Reset clears partial state
            jam = 1'b0;
            idm = 1'b0;
            busy = 1'b0;
            fail_now = 1'b0;
        end else if (busy) begin
            // Only suspend gets through an erase
            if (ers && dq_out == `CMD_SUSPEND) busy = 1'b0;
        end else if (!jam) step(flash_addr, dq_out);
    end

    // Status while busy, then array
    always @(posedge rd) begin
        if (busy && ers && !chip && flash_addr[20:15] != pa[20:15])
            bad_polls++; // Host polls outside the block
        if (idm && !flash_addr[6] && flash_addr[1:0] == 2'h2)
            rd_val = {15'h0000, flash_addr[20:15] == prot_blk};
        else if (busy) begin
            tgl = !tgl;
            rd_val = {8'h00, !ers && !pd[7], tgl, fail_now, 5'h00};
            left--;
            if (!fail_now && left <= 0) begin
                busy = 1'b0;
                if (!ers) mem[pa] = (mem.exists(pa) ? mem[pa] : 16'hFFFF) & pd;
                else foreach (mem[k])
                    if (chip || k[20:15] == pa[20:15]) mem[k] = 16'hFFFF;
            end
        end else
            rd_val = mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
    end

    // Low supply aborts for good
    always @(negedge supply_ok) begin
        busy = 1'b0;
        seq = 3'h0;
    end
endmodule : flash_dev_model

// >>> dv/flash_host_tb_top.sv
// Purpose: Bench for the flash host controller
// Assumes: 40 MHz mclk, model die
// Notes:   Die busy time set per test
`timescale 1ns/1ps

module flash_host_tb_top;
    logic        mclk = 1'b0, rst = 1'b1, req = 1'b0, supply_ok = 1'b1;
    flash_host_pkg::op_t op = flash_host_pkg::op_read;
    logic [20:0] req_addr = 21'h000000, flash_addr;
    logic [15:0] req_data = 16'h0000, rsp_data_reg, dq_out, dq_in;
    logic        ack, busy, rsp_fail_reg, suspended_reg, dq_oe, we_n, oe_n;
    logic        flash_select_n, sram_select_low_n, sram_select_high;
    logic        ready_busy_pullup_en, rb_low, bsy;
    int          fail_count = 0, checks_done = 0, rb_falls = 0;
    wire         rb = rb_low ? 1'b0 : 1'b1; // Board pull-up

    always #12.5 mclk = ~mclk;
    always @(negedge rb) rb_falls++;

    flash_host DUT (.mclk, .rst, .req, .op, .req_addr, .req_data,
        .supply_ok, .ack, .busy, .rsp_data_reg, .rsp_fail_reg,
        .suspended_reg, .flash_addr, .dq_out, .dq_oe, .dq_in, .we_n, .oe_n,
        .flash_select_n, .sram_select_low_n, .sram_select_high,
        .ready_busy_pullup_en, .ready_busy_out(rb));
    flash_dev_model flash_dev (.flash_addr, .dq_out, .we_n, .oe_n,
        .flash_select_n, .supply_ok, .dq_in, .rb_low);

    task automatic check(input string s, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", s, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    // One-cycle request
    task automatic start(input flash_host_pkg::op_t o,
                         input logic [20:0] a, input logic [15:0] d);
        @(negedge mclk);
        op = o;
        req_addr = a;
        req_data = d;
        req = 1'b1;
        @(negedge mclk);
        req = 1'b0;
    endtask : start

    task automatic wait_ack;
        int n;
        n = 0;
        while (ack !== 1'b1 && n < 40000) begin
            @(negedge mclk);
            n++;
        end
        check("ack", 16'(ack), 16'h0001);
    endtask : wait_ack

    task automatic run(input flash_host_pkg::op_t o,
                       input logic [20:0] a, input logic [15:0] d);
        start(o, a, d);
        wait_ack();
    endtask : run

    task automatic rd_chk(input logic [20:0] a, input logic [15:0] e);
        run(flash_host_pkg::op_read, a, 16'h0000);
        check("read data", rsp_data_reg, e);
    endtask : rd_chk

    initial begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        // Quick and slow program
        flash_dev.busy_reads = 3;
        run(flash_host_pkg::op_program, 21'h001234, 16'h5A3C);
        check("prog fail", 16'(rsp_fail_reg), 16'h0000);
        check("pin fell", 16'(rb_falls), 16'h0001);
        rd_chk(21'h001234, 16'h5A3C);
        flash_dev.busy_reads = 30;
        run(flash_host_pkg::op_program, 21'h0A0010, 16'h0F0F);
        check("pin fell", 16'(rb_falls), 16'h0002);
        rd_chk(21'h0A0010, 16'h0F0F);
        $display("test program done");
        // Block then chip erase
        run(flash_host_pkg::op_block_erase, 21'h0A0000, 16'h0000);
        rd_chk(21'h0A0010, 16'hFFFF);
        rd_chk(21'h001234, 16'h5A3C);
        check("poll addr", 16'(flash_dev.bad_polls), 16'h0000);
        run(flash_host_pkg::op_chip_erase, 21'h000000, 16'h0000);
        rd_chk(21'h001234, 16'hFFFF);
        $display("test erase done");
        // Suspend, resume on idle die
        run(flash_host_pkg::op_suspend, 21'h000000, 16'h0000);
        check("suspended", 16'(suspended_reg), 16'h0001);
        run(flash_host_pkg::op_resume, 21'h000000, 16'h0000);
        check("suspended", 16'(suspended_reg), 16'h0000);
        $display("test suspend done");
        // Failed program, then reset
        flash_dev.fail_next = 1'b1;
        run(flash_host_pkg::op_program, 21'h000200, 16'h1111);
        check("fail flag", 16'(rsp_fail_reg), 16'h0001);
        check("pin high", 16'(rb), 16'h0001);
        $display("test failure done");
        // Protection query
        flash_dev.prot_blk = 6'h05;
        run(flash_host_pkg::op_protect_query, 21'h028000, 16'h0000);
        check("protected", 16'(rsp_fail_reg), 16'h0001);
        run(flash_host_pkg::op_protect_query, 21'h030000, 16'h0000);
        check("protected", 16'(rsp_fail_reg), 16'h0000);
        // Stale partial sequence cleared first
        flash_dev.jam = 1'b1;
        run(flash_host_pkg::op_program, 21'h000300, 16'h00C3);
        rd_chk(21'h000300, 16'h00C3);
        $display("test protect done");
        // Low supply refuses, then aborts
        supply_ok = 1'b0;
        repeat (4) @(negedge mclk);
        start(flash_host_pkg::op_read, 21'h000000, 16'h0000);
        bsy = 1'b0;
        repeat (40) @(negedge mclk) bsy = bsy | busy;
        check("refused", 16'(bsy), 16'h0000);
        supply_ok = 1'b1;
        repeat (4) @(negedge mclk);
        flash_dev.busy_reads = 3000;
        start(flash_host_pkg::op_program, 21'h000400, 16'h2222);
        repeat (300) @(negedge mclk);
        supply_ok = 1'b0;
        wait_ack();
        check("abort flag", 16'(rsp_fail_reg), 16'h0001);
        supply_ok = 1'b1;
        repeat (4) @(negedge mclk);
        rd_chk(21'h000400, 16'hFFFF);
        flash_dev.busy_reads = 3;
        run(flash_host_pkg::op_program, 21'h000400, 16'h2222);
        rd_chk(21'h000400, 16'h2222);
        check("pin idle", 16'(rb), 16'h0001);
        $display("test lockout done");
        final_report();
    end

    // Run needs under 20k cycles
    initial begin
        repeat (95000) @(posedge mclk);
        fail_count++;
        final_report();
    end
endmodule : flash_host_tb_top

bind flash_host flash_host_props chk (.mclk, .rst, .supply_ok, .ack,
    .busy, .flash_addr, .dq_out, .dq_oe, .we_n, .oe_n, .flash_select_n,
    .sram_select_low_n, .sram_select_high, .ready_busy_pullup_en);
